// ### common/vic_consts.vh
// Constants of the regulator control register bank: offsets, fields, defaults, timing.
// Assumes inclusion by bare name from design files compiled with this folder on the path.
//
// Contract
// R1: Level register 0x00: parity bit7, code default 0110010
// R2: Control bit7 set selects internal level code
// R3: Writing bit7 zero returns to external control
// R4: Control bit4 suppresses protection during code change
// R5: Control bit3: 0 PFM, 1 fixed pulse
// R6: Control bit0: 0 auto-recover, 1 latch-off
// R7: Supply loss, lockout or disable restore defaults
// R8: Master sends odd parity over level byte
// R9: Parity error: no acknowledge, register unchanged
// R10: Level read returns stored parity and code
// R11: Serial inputs ignore glitches up to 32 ns
// R12: Master serial clock at most 400 kHz; bench master clocks at 2.5 MHz
// R13: Acknowledge own address on ninth clock, else ignore
// R14: Bit after address: 0 write, 1 read
// R15: After read byte, idle on STOP regardless
// R16: Control bits 6,5,2,1 read zero, ignore writes
// R17: Write: offset byte first, then data byte
`ifndef VIC_CONSTS_VH
`define VIC_CONSTS_VH

// Register offsets
`define VIC_OFFS_LEVEL       8'h00
`define VIC_OFFS_CTRL        8'h01

// Control field positions
`define VIC_CTRL_INTERNAL    7
`define VIC_CTRL_CHG_SUPPR   4
`define VIC_CTRL_FIXED_PULSE 3
`define VIC_CTRL_LATCH_OFF   0
`define VIC_CTRL_MASK        8'h99

// Reset values: parity 0 plus code 0110010, control 0000_1001
`define VIC_LEVEL_RESET      8'h32
`define VIC_CTRL_RESET       8'h09

// Timing figures
`define VIC_CLK_KHZ          20000
`define VIC_T_SPIKE_NS       32
`define VIC_T_CHANGE_NS      15000

// Neutral default target address
`define VIC_TARGET_ADDR      7'h50

`endif

// ### hw/vic_bus_events.v
// Edge and bus condition detector on filtered serial clock and data.
// Assumes both inputs are already synchronous to clk.
`default_nettype none
module vic_bus_events (
   // Clock and reset
   input  wire clk,
   input  wire sys_rst,
   // Filtered levels
   input  wire scl_lvl,
   input  wire sda_lvl,
   // One-cycle events
   output reg  scl_rise_ff,
   output reg  scl_fall_ff,
   output reg  start_ff,
   output reg  stop_ff
);
   reg scl_prev_ff;                          // Clock one cycle ago
   reg sda_prev_ff;                          // Data one cycle ago

   // Data moving while clock high marks START or STOP
   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         scl_prev_ff <= 1'b1;
         sda_prev_ff <= 1'b1;
         scl_rise_ff <= 1'b0;
         scl_fall_ff <= 1'b0;
         start_ff    <= 1'b0;
         stop_ff     <= 1'b0;
      end
      else
      begin
         scl_prev_ff <= scl_lvl;
         sda_prev_ff <= sda_lvl;
         scl_rise_ff <= scl_lvl & ~scl_prev_ff;
         scl_fall_ff <= ~scl_lvl & scl_prev_ff;
         start_ff    <= scl_lvl & scl_prev_ff & sda_prev_ff & ~sda_lvl;
         stop_ff     <= scl_lvl & scl_prev_ff & ~sda_prev_ff & sda_lvl;
      end
   end
endmodule // vic_bus_events
`default_nettype wire

// ### hw/vic_pin_filter.v
// Two-flop synchroniser plus spike filter for one serial pin.
// Assumes pin is asynchronous to clk; output changes only after a stable run.
`default_nettype none
module vic_pin_filter #(
   parameter integer STABLE_CYC = 1          // Extra samples a new level must hold
)(
   // Clock and reset
   input  wire clk,
   input  wire sys_rst,
   // Pin side
   input  wire pin_in,
   // Filtered level
   output reg  level_ff
);
   reg       sync1_ff;                       // First stage, read only by second
   reg       sync2_ff;                       // Second stage
   reg [3:0] run_ff;                         // Length of current differing run

   // Synchroniser chain; idle bus is high
   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         sync1_ff <= 1'b1;
         sync2_ff <= 1'b1;
      end
      else
      begin
         sync1_ff <= pin_in;
         sync2_ff <= sync1_ff;
      end
   end

   // Spike filter: one lone sample never flips the output [R11]
   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         level_ff <= 1'b1;
         run_ff   <= 4'h0;
      end
      else if (sync2_ff == level_ff)
         run_ff <= 4'h0;                     // Glitch gone, start over
      else if (run_ff >= STABLE_CYC[3:0])
      begin
         level_ff <= sync2_ff;               // Held long enough
         run_ff   <= 4'h0;
      end
      else
         run_ff <= run_ff + 4'h1;
   end
endmodule // vic_pin_filter
`default_nettype wire

// ### hw/vic_regbank.v
// Serial target with the level and control registers of the buck regulator.
// Assumes a serial master on open-drain pins and async supply status pins.
`include "vic_consts.vh"
`default_nettype none
module vic_regbank #(
   parameter [6:0] TARGET_ADDR = `VIC_TARGET_ADDR,        // Arbitrary neutral address
   parameter integer CHANGE_CYC =                          // Protection hold-off after code change
      (`VIC_T_CHANGE_NS * (`VIC_CLK_KHZ / 1000)) / 1000
)(
   // Clock and reset
   input  wire       clk,
   input  wire       sys_rst,
   // Serial pins
   input  wire       scl_in,
   input  wire       sda_in,
   output reg        sda_out,
   output reg        sda_oe,
   // Supply status pins, asynchronous
   input  wire       input_supply_ok,
   input  wire       supply_lockout,
   input  wire       enable_in,
   // Regulator controls
   output wire [6:0] target_level_code,
   output wire       level_parity,
   output wire       internal_mode,
   output reg        protection_enable,
   output wire       light_load_fixed_pulse_select,
   output wire       latch_off_select
);
   // Spike length in whole cycles, at least one
   // Rounded up: a spike at the limit meets one sample, never two,
   // and the filter wants one sample more than this count
   localparam integer SPIKE_RAW = (`VIC_T_SPIKE_NS * (`VIC_CLK_KHZ / 1000) + 999) / 1000;
   localparam integer SPIKE_CYC = (SPIKE_RAW < 1) ? 1 : SPIKE_RAW;

   // Protocol states
   // ST_IGNORE also parks the engine after a wrong address
   localparam [2:0] ST_IDLE   = 3'd0;
   localparam [2:0] ST_ADDR   = 3'd1;
   localparam [2:0] ST_ACK    = 3'd2;
   localparam [2:0] ST_OFFS   = 3'd3;
   localparam [2:0] ST_DATA   = 3'd4;
   localparam [2:0] ST_SEND   = 3'd5;
   localparam [2:0] ST_MACK   = 3'd6;
   localparam [2:0] ST_IGNORE = 3'd7;

   wire        scl_f;                        // Filtered clock
   wire        sda_f;                        // Filtered data
   wire        scl_rise;                     // Clock edges and bus conditions
   wire        scl_fall;
   wire        bus_start;
   wire        bus_stop;

   reg  [2:0]  pwr_s1_ff;                    // Status synchroniser, first stage
   reg  [2:0]  pwr_s2_ff;                    // Status synchroniser, second stage
   reg         rst_all_ff;                   // Combined defaults request
   reg  [7:0]  level_ff;                     // Level register
   reg  [7:0]  ctrl_ff;                      // Control register, unused bits held zero
   reg  [2:0]  state_ff;                     // Protocol state
   reg  [2:0]  after_ack_ff;                 // State to enter once acknowledge ends
   reg  [7:0]  shift_ff;                     // Receive shifter
   reg  [7:0]  tx_ff;                        // Transmit shifter
   reg  [3:0]  bit_cnt_ff;                   // Bits moved in current byte
   reg         ptr_ff;                       // Selected register
   reg  [15:0] chg_cnt_ff;                   // Protection hold-off counter
   reg         chg_hit;                      // Level code changing this cycle
   reg  [7:0]  rd_byte;                      // Byte a read returns
   wire        parity_ok;                    // Odd count of ones in received byte

   // Input conditioning, one instance per pin
   vic_pin_filter #(.STABLE_CYC(SPIKE_CYC)) u_scl_filt (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .pin_in   (scl_in),
      .level_ff (scl_f)
   );
   vic_pin_filter #(.STABLE_CYC(SPIKE_CYC)) u_sda_filt (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .pin_in   (sda_in),
      .level_ff (sda_f)
   );

   // Bus events from filtered levels
   vic_bus_events u_events (
      .clk         (clk),
      .sys_rst     (sys_rst),
      .scl_lvl     (scl_f),
      .sda_lvl     (sda_f),
      .scl_rise_ff (scl_rise),
      .scl_fall_ff (scl_fall),
      .start_ff    (bus_start),
      .stop_ff     (bus_stop)
   );

   // Supply status synchronisers
   // Status pins come from the analog side; two flops keep
   // a slow or noisy edge away from the register reset
   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         pwr_s1_ff <= 3'h0;
         pwr_s2_ff <= 3'h0;
      end
      else
      begin
         pwr_s1_ff <= {input_supply_ok, supply_lockout, enable_in};
         pwr_s2_ff <= pwr_s1_ff;
      end
   end

   // Any lost condition forces defaults on registers, engine and hold-off [R7]
   // Registered so the register reset is glitch free; costs one
   // cycle of latency, far below any supply event
   always @(posedge clk)
   begin
      if (sys_rst)
         rst_all_ff <= 1'b1;
      else
         rst_all_ff <= ~pwr_s2_ff[2] | pwr_s2_ff[1] | ~pwr_s2_ff[0];
   end

   // Read data selection; unused control bits read zero [R10] [R16]
   // Copied into tx_ff at the address byte, so the byte sent
   // cannot tear while it is being shifted out
   always @*
   begin
      if (ptr_ff)
         rd_byte = ctrl_ff & `VIC_CTRL_MASK;
      else
         rd_byte = level_ff;
   end

   // Odd parity check over whole byte [R9]
   // Same check for both registers: a corrupt control byte
   // must not flip the regulator mode either
   assign parity_ok = ^shift_ff;

   // Code change flag for protection hold-off
   // Only a real change starts the hold-off; rewriting the
   // same code leaves protection untouched
   always @*
   begin
      chg_hit = (state_ff == ST_DATA) && scl_fall && (bit_cnt_ff == 4'd8) && parity_ok
                && !ptr_ff && (shift_ff[6:0] != level_ff[6:0]);
   end

   // Protocol engine and register writes
   // Bits are taken at detected clock rise and driven at detected
   // clock fall, both behind the pin filter, so data we drive
   // always moves while the clock is low
   always @(posedge clk)
   begin
      if (sys_rst || rst_all_ff)
      begin
         level_ff     <= `VIC_LEVEL_RESET;   // [R1] [R7]
         ctrl_ff      <= `VIC_CTRL_RESET;    // [R5] [R6] [R7]
         state_ff     <= ST_IDLE;
         after_ack_ff <= ST_IDLE;
         shift_ff     <= 8'h00;
         tx_ff        <= 8'h00;
         bit_cnt_ff   <= 4'h0;
         ptr_ff       <= 1'b0;
         sda_oe       <= 1'b0;
         sda_out      <= 1'b0;
      end
      else if (bus_start)
      begin
         // Every START restarts address compare [R13]
         state_ff   <= ST_ADDR;
         bit_cnt_ff <= 4'h0;
         sda_oe     <= 1'b0;
      end
      else if (bus_stop)
      begin
         // STOP always ends the transfer [R15]
         state_ff <= ST_IDLE;
         sda_oe   <= 1'b0;
      end
      else
      begin
         case (state_ff)
            ST_ADDR, ST_OFFS, ST_DATA:
            begin
               if (scl_rise && bit_cnt_ff != 4'd8)
               begin
                  shift_ff   <= {shift_ff[6:0], sda_f};
                  bit_cnt_ff <= bit_cnt_ff + 4'h1;
               end
               else if (scl_fall && bit_cnt_ff == 4'd8)
               begin
                  // Byte complete: decide acknowledge for ninth clock
                  bit_cnt_ff <= 4'h0;
                  state_ff   <= ST_IGNORE;   // Default: no acknowledge
                  if (state_ff == ST_ADDR)
                  begin
                     if (shift_ff[7:1] == TARGET_ADDR) // [R13]
                     begin
                        sda_oe       <= 1'b1;
                        state_ff     <= ST_ACK;
                        tx_ff        <= rd_byte;
                        after_ack_ff <= shift_ff[0] ? ST_SEND : ST_OFFS; // [R14]
                     end
                  end
                  else if (state_ff == ST_OFFS)
                  begin
                     // Offset byte selects register [R17]
                     if (shift_ff == `VIC_OFFS_LEVEL || shift_ff == `VIC_OFFS_CTRL)
                     begin
                        sda_oe       <= 1'b1;
                        state_ff     <= ST_ACK;
                        ptr_ff       <= shift_ff[0];
                        after_ack_ff <= ST_DATA;
                     end
                  end
                  else if (parity_ok)        // Corrupt byte: no ack, no store [R9]
                  begin
                     sda_oe       <= 1'b1;
                     state_ff     <= ST_ACK;
                     after_ack_ff <= ST_IGNORE;
                     if (ptr_ff)
                        ctrl_ff <= shift_ff & `VIC_CTRL_MASK; // [R2] [R3] [R4] [R5] [R6] [R16]
                     else
                        level_ff <= shift_ff; // Parity kept for read back [R1] [R10]
                  end
               end
            end
            ST_ACK:
            begin
               if (scl_fall)
               begin
                  // Ninth clock over: release or present first read bit
                  state_ff   <= after_ack_ff;
                  bit_cnt_ff <= 4'h0;
                  sda_oe     <= 1'b0;
                  if (after_ack_ff == ST_SEND)
                  begin
                     sda_oe     <= ~tx_ff[7];
                     tx_ff      <= {tx_ff[6:0], 1'b0};
                     bit_cnt_ff <= 4'h1;
                  end
               end
            end
            ST_SEND:
            begin
               if (scl_fall)
               begin
                  if (bit_cnt_ff == 4'd8)
                  begin
                     sda_oe   <= 1'b0;       // Leave line to master
                     state_ff <= ST_MACK;
                  end
                  else
                  begin
                     sda_oe     <= ~tx_ff[7];
                     tx_ff      <= {tx_ff[6:0], 1'b0};
                     bit_cnt_ff <= bit_cnt_ff + 4'h1;
                  end
               end
            end
            ST_MACK:
            begin
               // Master answer is not acted on; wait for STOP [R15]
               if (scl_rise)
                  state_ff <= ST_IGNORE;
            end
            ST_IGNORE, ST_IDLE:
               sda_oe <= 1'b0;               // Silent until START
            default:
               state_ff <= ST_IDLE;
         endcase
      end
   end

   // Protection hold-off while the level code moves [R4]
   // Counter loads even with suppression off; the control bit
   // only gates the output, so setting it late drops protection for the remaining count
   always @(posedge clk)
   begin
      if (sys_rst || rst_all_ff)
      begin
         chg_cnt_ff        <= 16'h0000;
         protection_enable <= 1'b1;
      end
      else
      begin
         if (chg_hit)
            chg_cnt_ff <= CHANGE_CYC[15:0];
         else if (chg_cnt_ff != 16'h0000)
            chg_cnt_ff <= chg_cnt_ff - 16'h0001;
         // Suppression only when enabled; otherwise protection stays on
         protection_enable <= ~(ctrl_ff[`VIC_CTRL_CHG_SUPPR] & (chg_hit | (chg_cnt_ff != 16'h0000)));
      end
   end

   // Register fields straight to the regulator
   // Plain wires from flops; no extra pipeline stage
   assign target_level_code             = level_ff[6:0];
   assign level_parity                  = level_ff[7];
   assign internal_mode                 = ctrl_ff[`VIC_CTRL_INTERNAL];    // [R2] [R3]
   assign light_load_fixed_pulse_select = ctrl_ff[`VIC_CTRL_FIXED_PULSE]; // [R5]
   assign latch_off_select              = ctrl_ff[`VIC_CTRL_LATCH_OFF];   // [R6]
endmodule // vic_regbank
`default_nettype wire

// ### tb/test_vic_regbank.sv
// Self-checking bench for the regulator register bank over its serial link.
// Assumes vic_master on the link and vic_monitor bound to the design.
`default_nettype none
module test_vic_regbank;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int         CHG  = 5;                 // Shortened hold-off keeps the run brief
   localparam logic [6:0] ADDR = 7'h50;             // Design default address
   logic                  clk, sys_rst, input_supply_ok, supply_lockout, enable_in;
   logic                  scl, m_sda_low, spike, prot_low_seen;
   wire logic             sda_oe, sda_out, par, internal_mode, prot_en, fixed_pulse, latch_off;
   wire logic [6:0]       code;
   wire logic             sda_line = (sda_oe ? sda_out : 1'b1) & ~m_sda_low;   // Pull-up, wired low
   int                    errors, samples_checked;
   vic_regbank #(.CHANGE_CYC(CHG)) u_dut (
      .clk(clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
      .input_supply_ok(input_supply_ok), .supply_lockout(supply_lockout), .enable_in(enable_in),
      .target_level_code(code), .level_parity(par), .internal_mode(internal_mode), .protection_enable(prot_en),
      .light_load_fixed_pulse_select(fixed_pulse), .latch_off_select(latch_off));
   vic_master u_master (.scl(scl), .sda_low(m_sda_low), .sda_wire(sda_line), .spike(spike));
   // 20 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Remember any protection hold-off once out of reset
   always @(posedge clk)
      if (sys_rst)
         prot_low_seen <= 1'b0;
      else if (prot_en !== 1'b1)
         prot_low_seen <= 1'b1;
   // Odd parity over the byte: top bit is the XNOR of the code
   function automatic logic [7:0] lvl(input logic [6:0] c);
      return {~^c, c};
   endfunction
   task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Address, offset, one data byte; acknowledges compared as {addr, offset, data}
   task automatic wr(input logic [6:0] a, input logic [7:0] off, input logic [7:0] d, input logic [2:0] ek);
      logic [7:0] rx;
      logic [2:0] k;
      u_master.start_cond();
      u_master.xfer({a, 1'b0}, 1'b1, rx, k[2]);
      u_master.xfer(off, 1'b1, rx, k[1]);
      u_master.xfer(d, 1'b1, rx, k[0]);
      u_master.stop_cond();
      check("write acks", {5'h00, k}, {5'h00, ek});
   endtask
   // Select offset, repeated START, read one byte and compare it
   task automatic rd(input logic [7:0] off, input logic mack, input logic [7:0] exp);
      logic [7:0] v;
      logic       k;
      u_master.start_cond();
      u_master.xfer({ADDR, 1'b0}, 1'b1, v, k);
      u_master.xfer(off, 1'b1, v, k);
      u_master.start_cond();
      u_master.xfer({ADDR, 1'b1}, 1'b1, v, k);
      u_master.xfer(8'hFF, mack, v, k);
      u_master.stop_cond();
      check("read data", v, exp);
   endtask
   // Level byte and {internal, fixed pulse, latch} at the control outputs
   task automatic ports(input logic [7:0] el, input logic [2:0] ec);
      check("level port", {par, code}, el);
      check("ctrl port", {5'h00, internal_mode, fixed_pulse, latch_off}, {5'h00, ec});
   endtask
   task automatic print_verdict();
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Watchdog, several times the expected run
   initial
   begin
      #3000000;
      errors++;
      print_verdict();
   end
   // Control writes: data sent, byte read back, {internal, fixed pulse, latch}
   logic [7:0] ctl_tx [3] = '{8'hFE, 8'h01, 8'h10};
   logic [7:0] ctl_rx [3] = '{8'h98, 8'h01, 8'h10};
   logic [2:0] ctl_pt [3] = '{3'b110, 3'b001, 3'b000};
   initial
   begin
      errors = 0;
      samples_checked = 0;
      spike = 1'b0;
      sys_rst = 1'b1;
      input_supply_ok = 1'b1;
      supply_lockout = 1'b0;
      enable_in = 1'b1;
      repeat (2) @(negedge clk);
      sys_rst = 1'b0;
      repeat (5) @(negedge clk);
      ports(8'h32, 3'b011);
      rd(8'h00, 1'b1, 8'h32);
      rd(8'h01, 1'b1, 8'h09);
      wr(ADDR, 8'h00, lvl(7'h15), 3'b111);
      ports(8'h15, 3'b011);
      check("hold-off without suppress", {7'h00, prot_low_seen}, 8'h00);
      wr(ADDR, 8'h00, lvl(7'h40) ^ 8'h80, 3'b110);
      wr(ADDR ^ 7'h01, 8'h00, lvl(7'h22), 3'b000);
      ports(8'h15, 3'b011);
      for (int i = 0; i < 3; i++)
      begin
         wr(ADDR, 8'h01, ctl_tx[i], 3'b111);
         ports(8'h15, ctl_pt[i]);
         rd(8'h01, 1'b1, ctl_rx[i]);
      end
      wr(ADDR, 8'h01, 8'h03, 3'b110);
      rd(8'h01, 1'b1, 8'h10);
      spike = 1'b1;
      wr(ADDR, 8'h00, lvl(7'h7F), 3'b111);
      spike = 1'b0;
      check("hold-off with suppress", {7'h00, prot_low_seen}, 8'h01);
      rd(8'h00, 1'b0, 8'h7F);
      rd(8'h00, 1'b1, 8'h7F);
      for (int i = 0; i < 3; i++)
      begin
         wr(ADDR, 8'h01, 8'h01, 3'b111);
         @(negedge clk);
         input_supply_ok = (i != 0);
         supply_lockout = (i == 1);
         enable_in = (i != 2);
         repeat (6) @(negedge clk);
         input_supply_ok = 1'b1;
         supply_lockout = 1'b0;
         enable_in = 1'b1;
         repeat (6) @(negedge clk);
         ports(8'h32, 3'b011);
      end
      print_verdict();
   end
endmodule // test_vic_regbank
`default_nettype wire

// ### tb/vic_master.sv
// Behavioural serial bus master for the register bank's link.
// Assumes the bench resolves the open-drain data line with a pull-up.
`default_nettype none
module vic_master (
   // Link clock, stands still high between frames
   output logic      scl,
   // High while the master pulls data low
   output logic      sda_low,
   // Resolved data line and spike request
   input  wire logic sda_wire,
   input  wire logic spike
);
   timeunit 1ns;
   timeprecision 1ns;
   // Idle bus: both lines released
   initial
   begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // One 400 ns bit; long low phase leaves room for the target's pin latency
   // Faster than a real master may clock; the target only needs settled levels
   task automatic bit_io(input logic b, output logic r);
      scl = 1'b0;
      #30 sda_low = ~b;
      #250 scl = 1'b1;
      if (spike && b)
      begin
         // 30 ns dip while clock high looks like START then STOP
         #20 sda_low = 1'b1;
         #30 sda_low = 1'b0;
         #60 r = sda_wire;
      end
      else
         #110 r = sda_wire;
      #10;
   endtask
   // START, also usable as repeated START
   task automatic start_cond();
      scl = 1'b0;
      #30 sda_low = 1'b0;
      #370 scl = 1'b1;
      #300 sda_low = 1'b1;
      #300;
   endtask
   // STOP, bus left released
   task automatic stop_cond();
      scl = 1'b0;
      #30 sda_low = 1'b1;
      #370 scl = 1'b1;
      #300 sda_low = 1'b0;
      #300;
   endtask
   // Byte MSB first, ninth bit carries mack; returns byte seen and target acknowledge
   task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx, output logic ack);
      logic a;
      for (int i = 7; i >= 0; i--)
         bit_io(tx[i], rx[i]);
      bit_io(mack, a);
      ack = ~a;
   endtask
endmodule // vic_master
`default_nettype wire

// ### tb/vic_monitor.sv
// Concurrent checks on the regulator register bank, seen only at its ports.
// Assumes a bind onto vic_regbank; one clock domain, synchronous reset sys_rst.
`default_nettype none
module vic_monitor #(
   parameter integer CHANGE_CYC = 300              // Protection hold-off length
)(
   // Clock and reset
   input wire logic       clk,
   input wire logic       sys_rst,
   // Serial pins
   input wire logic       scl_in,
   input wire logic       sda_in,
   input wire logic       sda_out,
   input wire logic       sda_oe,
   // Supply status
   input wire logic       input_supply_ok,
   input wire logic       supply_lockout,
   input wire logic       enable_in,
   // Regulator controls
   input wire logic [6:0] target_level_code,
   input wire logic       level_parity,
   input wire logic       internal_mode,
   input wire logic       protection_enable,
   input wire logic       light_load_fixed_pulse_select,
   input wire logic       latch_off_select
);
   timeunit 1ns;
   timeprecision 1ns;
   wire logic       bad_supply = !input_supply_ok || supply_lockout || !enable_in;   // Any default-forcing state
   wire logic [7:0] level      = {level_parity, target_level_code};                 // Stored level byte
   wire logic [2:0] ctrl       = {internal_mode, light_load_fixed_pulse_select, latch_off_select};
   logic [15:0]     low_cnt_ff;                                                      // Cycles protection is off
   logic [15:0]     nxt_low_cnt;
   // Count how long protection has been held off
   always_comb
   begin
      nxt_low_cnt = protection_enable ? 16'h0000 : low_cnt_ff + 16'h0001;
   end
   // Counter register, cleared by reset
   always_ff @(posedge clk)
   begin
      low_cnt_ff <= sys_rst ? 16'h0000 : nxt_low_cnt;
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   a_reset_defaults: assert property ($fell(sys_rst) |-> level == 8'h32 && ctrl == 3'b011 && protection_enable && !sda_oe)
      else $error("defaults missing after reset");
   a_supply_defaults: assert property (bad_supply [*5] |-> level == 8'h32 && ctrl == 3'b011 && !sda_oe)
      else $error("defaults missing while supply is bad");
   a_level_odd: assert property (^level)
      else $error("stored level byte has even parity");
   a_open_drain: assert property (!sda_out)
      else $error("data pin driven high");
   // Registers only move after serial clock activity or a supply event
   a_quiet_regs: assert property ((scl_in && !bad_supply) [*8] |=> $stable(level) && $stable(ctrl))
      else $error("register changed on a quiet bus");
   a_prot_cause: assert property ($fell(protection_enable) |-> target_level_code != $past(target_level_code))
      else $error("protection dropped without a code change");
   a_suppress_len: assert property ($rose(protection_enable) |-> low_cnt_ff == CHANGE_CYC + 1)
      else $error("protection hold-off has the wrong length");
   a_suppress_bound: assert property (low_cnt_ff <= CHANGE_CYC + 1)
      else $error("protection held off too long");
endmodule // vic_monitor
bind vic_regbank vic_monitor #(.CHANGE_CYC(CHANGE_CYC)) u_monitor (
   .clk(clk), .sys_rst(sys_rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
   .input_supply_ok(input_supply_ok), .supply_lockout(supply_lockout), .enable_in(enable_in),
   .target_level_code(target_level_code), .level_parity(level_parity), .internal_mode(internal_mode),
   .protection_enable(protection_enable), .light_load_fixed_pulse_select(light_load_fixed_pulse_select),
   .latch_off_select(latch_off_select));
`default_nettype wire
